// file: src/pft_pkg.sv
// Purpose: Shared constants and types for the program flash table access block.
// Assumes: One system clock, asynchronous active-high reset.
// Notes: Addresses are byte-style program addresses; one instruction spans two.
package pft_pkg;
  localparam int ADDR_W = 24;
  localparam int PAGE_W = 8;
  localparam int EA_W = 16;
  localparam int DATA_W = 16;
  localparam int INSTR_W = 24;
  localparam int BYTE_W = 8;
  localparam int LOW_MSB = 15;
  localparam int HIGH_LSB = 16;
  localparam int HIGH_MSB = 23;
  localparam int ROW_INSTR = 64;
  localparam int ROW_BYTES = 192;
  localparam int ROW_IDX_W = 6;
  localparam int PAGE_INSTR = 512;
  localparam int PAGE_BYTES = 1536;
  localparam int STEP_W = 10;
  localparam int FLASH_INSTR = 16384;
  localparam int SER_PAIRS = 3;
  localparam int SER_CMD_W = 3;
  localparam int SER_FRAME_W = SER_CMD_W + ADDR_W + DATA_W;
  localparam int SER_CNT_W = 6;
  localparam int SER_OUT_CNT_W = 5;
  localparam logic [INSTR_W-1:0] ERASED_WORD = 24'hFF_FFFF;
  localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h00;
  localparam logic [SER_CMD_W-1:0] SER_RD_LOW = 3'h0;
  localparam logic [SER_CMD_W-1:0] SER_RD_HIGH = 3'h1;
  localparam logic [SER_CMD_W-1:0] SER_WR_LOW = 3'h2;
  localparam logic [SER_CMD_W-1:0] SER_WR_HIGH = 3'h3;
  localparam logic [SER_CMD_W-1:0] SER_ROW = 3'h4;
  localparam logic [SER_CMD_W-1:0] SER_WORD = 3'h5;
  localparam logic [SER_CMD_W-1:0] SER_ERASE = 3'h6;

  typedef enum logic [1:0] {PFT_RD_LOW, PFT_RD_HIGH, PFT_WR_LOW, PFT_WR_HIGH} pft_tbl_op_t;
  typedef enum logic [1:0] {PFT_NV_ROW, PFT_NV_WORD, PFT_NV_ERASE} pft_nv_cmd_t;
endpackage

// file: src/pft_nvm_if.sv
// Purpose: Carries flash program and erase sequencing between control and sequencer.
// Assumes: Same clock on both sides.
// Notes: Steps are issued one per clock while busy.
`timescale 1ns/1ps
interface pft_nvm_if;
  logic start;
  pft_pkg::pft_nv_cmd_t cmd;
  logic busy;
  logic step_valid;
  logic [pft_pkg::STEP_W-1:0] step_idx;
  logic done;
  modport ctl (output start, cmd, input busy, step_valid, step_idx, done);
  modport seq (input start, cmd, output busy, step_valid, step_idx, done);
endinterface

// file: src/pft_nvm_seq.sv
// Purpose: Steps through the words of a row program, word program or page erase.
// Assumes: Start is ignored while busy.
// Notes: Done pulses one clock after the last step.
`timescale 1ns/1ps
module pft_nvm_seq (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  pft_nvm_if.seq nv
);
  logic busy_ff;
  logic done_ff;
  logic [pft_pkg::STEP_W-1:0] cnt_ff;
  logic [pft_pkg::STEP_W-1:0] len_ff;
  logic [pft_pkg::STEP_W-1:0] nxt_len;
  logic [pft_pkg::STEP_W-1:0] seen_ff;

  always_comb begin
    unique case (nv.cmd)
      pft_pkg::PFT_NV_ROW: nxt_len = pft_pkg::STEP_W'(pft_pkg::ROW_INSTR);
      pft_pkg::PFT_NV_WORD: nxt_len = pft_pkg::STEP_W'(1);
      default: nxt_len = pft_pkg::STEP_W'(pft_pkg::PAGE_INSTR);
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      busy_ff <= 1'b0;
      cnt_ff <= '0;
      len_ff <= '0;
    end else if (!busy_ff && nv.start) begin
      busy_ff <= 1'b1;
      cnt_ff <= '0;
      len_ff <= nxt_len;
    end else if (busy_ff) begin
      cnt_ff <= cnt_ff + pft_pkg::STEP_W'(1);
      if (cnt_ff == len_ff - pft_pkg::STEP_W'(1)) begin
        busy_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= busy_ff && (cnt_ff == len_ff - pft_pkg::STEP_W'(1));
    end
  end

  assign nv.busy = busy_ff;
  assign nv.step_valid = busy_ff;
  assign nv.step_idx = cnt_ff;
  assign nv.done = done_ff;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      seen_ff <= '0;
    end else if (!busy_ff && nv.start) begin
      seen_ff <= '0;
    end else if (busy_ff) begin
      seen_ff <= seen_ff + pft_pkg::STEP_W'(1);
    end
  end

  property p_step_count;
    @(posedge clk_sys_in) disable iff (rst_in)
    done_ff |-> (seen_ff == len_ff) && !busy_ff;
  endproperty
  a_step_count: assert property (p_step_count) else $error("step count differs");

  property p_erase_len;
    @(posedge clk_sys_in) disable iff (rst_in)
    (!busy_ff && nv.start && nv.cmd == pft_pkg::PFT_NV_ERASE) |=> len_ff == 10'h200;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase length wrong");

  property p_word_len;
    @(posedge clk_sys_in) disable iff (rst_in)
    (!busy_ff && nv.start && nv.cmd == pft_pkg::PFT_NV_WORD) |=> busy_ff ##1 !busy_ff;
  endproperty
  a_word_len: assert property (p_word_len) else $error("word program not one step");
endmodule

// file: src/pft_top.sv
// Purpose: Table read/write access to program flash with row, word and page operations.
// Assumes: Flash content is not reset; it must be erased before it is read.
// Notes: Serial programming becomes active while master clear is held low.
`timescale 1ns/1ps
module pft_top #(
  parameter int FLASH_INSTR = pft_pkg::FLASH_INSTR,
  parameter int NUM_PAIRS = pft_pkg::SER_PAIRS
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic page_wr_in,
  input wire logic [pft_pkg::PAGE_W-1:0] page_data_in,
  output logic [pft_pkg::PAGE_W-1:0] table_page_select_out,
  input wire logic tbl_valid_in,
  output logic tbl_ready_out,
  input wire pft_pkg::pft_tbl_op_t tbl_op_in,
  input wire logic tbl_byte_mode_in,
  input wire logic [pft_pkg::EA_W-1:0] operand_pointer_address_in,
  input wire logic [pft_pkg::DATA_W-1:0] tbl_wdata_in,
  output logic tbl_ack_out,
  output logic [pft_pkg::DATA_W-1:0] tbl_rdata_out,
  input wire logic nv_valid_in,
  input wire pft_pkg::pft_nv_cmd_t nv_cmd_in,
  output logic nv_busy_out,
  output logic nv_done_out,
  input wire logic master_clear_reset_n_in,
  input wire logic [NUM_PAIRS-1:0] prog_serial_clock_pin_in,
  input wire logic [NUM_PAIRS-1:0] prog_serial_data_pin_in,
  output logic [NUM_PAIRS-1:0] prog_serial_data_pin_out,
  output logic [NUM_PAIRS-1:0] prog_serial_data_pin_oe_out,
  output logic serial_mode_out
);
  localparam int IDX_W = $clog2(FLASH_INSTR);

  logic [pft_pkg::INSTR_W-1:0] mem_ff [FLASH_INSTR];
  logic [pft_pkg::INSTR_W-1:0] latch_ff [pft_pkg::ROW_INSTR];
  logic [pft_pkg::PAGE_W-1:0] page_ff;
  logic ack_ff;
  logic ack_ser_ff;
  logic [pft_pkg::DATA_W-1:0] rdata_ff;
  logic [IDX_W-1:0] base_ff;
  pft_pkg::pft_nv_cmd_t nv_cmd_ff;
  logic [NUM_PAIRS-1:0] ck_s1_ff, ck_s2_ff, ck_d_ff, dt_s1_ff, dt_s2_ff;
  logic master_clear_reset_s1_ff, master_clear_reset_s2_ff;
  logic lock_ff;
  logic [NUM_PAIRS-1:0] pair_ff;
  logic [pft_pkg::SER_FRAME_W-1:0] frame_ff;
  logic [pft_pkg::SER_CNT_W-1:0] fcnt_ff;
  logic frame_rdy_ff;
  logic [pft_pkg::DATA_W-1:0] sout_ff;
  logic [pft_pkg::SER_OUT_CNT_W-1:0] scnt_ff;
  logic ser_mode;
  logic [NUM_PAIRS-1:0] rise;
  logic [NUM_PAIRS-1:0] nxt_pair;
  logic act_rise;
  logic act_data;
  logic op_go;
  logic op_ser;
  pft_pkg::pft_tbl_op_t op_kind;
  logic op_byte;
  logic [pft_pkg::ADDR_W-1:0] op_addr;
  logic [pft_pkg::DATA_W-1:0] op_wdata;
  logic nv_go;
  pft_pkg::pft_nv_cmd_t nv_kind;
  logic [IDX_W-1:0] op_idx;
  logic [pft_pkg::ROW_IDX_W-1:0] lat_idx;
  logic [pft_pkg::SER_CMD_W-1:0] f_cmd;
  logic [pft_pkg::ADDR_W-1:0] f_addr;
  logic [pft_pkg::DATA_W-1:0] f_data;

  pft_nvm_if nv ();

  pft_nvm_seq u_seq (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .nv(nv)
  );

  function automatic logic [pft_pkg::DATA_W-1:0] fmt_read(input pft_pkg::pft_tbl_op_t op,
      input logic bm, input logic a0, input logic [pft_pkg::INSTR_W-1:0] w);
    logic [pft_pkg::DATA_W-1:0] r;
    r = '0;
    if (op == pft_pkg::PFT_RD_LOW) begin
      if (!bm) begin
        r = w[pft_pkg::LOW_MSB:0];
      end else begin
        r = {8'h00, a0 ? w[pft_pkg::LOW_MSB:pft_pkg::BYTE_W] : w[pft_pkg::BYTE_W-1:0]};
      end
    end else if (!bm || !a0) begin
      r = {8'h00, w[pft_pkg::HIGH_MSB:pft_pkg::HIGH_LSB]};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Serial programming pins.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ck_s1_ff <= '0;
      ck_s2_ff <= '0;
      ck_d_ff <= '0;
      dt_s1_ff <= '0;
      dt_s2_ff <= '0;
      master_clear_reset_s1_ff <= 1'b1;
      master_clear_reset_s2_ff <= 1'b1;
    end else begin
      ck_s1_ff <= prog_serial_clock_pin_in;
      ck_s2_ff <= ck_s1_ff;
      ck_d_ff <= ck_s2_ff;
      dt_s1_ff <= prog_serial_data_pin_in;
      dt_s2_ff <= dt_s1_ff;
      master_clear_reset_s1_ff <= master_clear_reset_n_in;
      master_clear_reset_s2_ff <= master_clear_reset_s1_ff;
    end
  end

  assign ser_mode = !master_clear_reset_s2_ff;
  assign rise = ck_s2_ff & ~ck_d_ff;

  // The first pair to clock after entry is taken; the others are ignored.
  always_comb begin
    nxt_pair = '0;
    for (int p = NUM_PAIRS - 1; p >= 0; p--) begin
      if (rise[p]) begin
        nxt_pair = '0;
        nxt_pair[p] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      lock_ff <= 1'b0;
      pair_ff <= '0;
    end else if (!ser_mode) begin
      lock_ff <= 1'b0;
      pair_ff <= '0;
    end else if (!lock_ff && |rise) begin
      lock_ff <= 1'b1;
      pair_ff <= nxt_pair;
    end
  end

  assign act_rise = lock_ff ? |(rise & pair_ff) : |rise;
  assign act_data = lock_ff ? |(dt_s2_ff & pair_ff) : |(dt_s2_ff & nxt_pair);

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      frame_ff <= '0;
      fcnt_ff <= '0;
      frame_rdy_ff <= 1'b0;
    end else begin
      frame_rdy_ff <= 1'b0;
      if (!ser_mode) begin
        fcnt_ff <= '0;
      end else if (act_rise && scnt_ff == '0) begin
        frame_ff <= {frame_ff[pft_pkg::SER_FRAME_W-2:0], act_data};
        if (fcnt_ff == pft_pkg::SER_CNT_W'(pft_pkg::SER_FRAME_W - 1)) begin
          fcnt_ff <= '0;
          frame_rdy_ff <= 1'b1;
        end else begin
          fcnt_ff <= fcnt_ff + pft_pkg::SER_CNT_W'(1);
        end
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      sout_ff <= '0;
      scnt_ff <= '0;
    end else if (!ser_mode) begin
      scnt_ff <= '0;
    end else if (ack_ff && ack_ser_ff) begin
      sout_ff <= rdata_ff;
      scnt_ff <= pft_pkg::SER_OUT_CNT_W'(pft_pkg::DATA_W);
    end else if (act_rise && scnt_ff != '0) begin
      sout_ff <= {sout_ff[pft_pkg::DATA_W-2:0], 1'b0};
      scnt_ff <= scnt_ff - pft_pkg::SER_OUT_CNT_W'(1);
    end
  end

  assign prog_serial_data_pin_out = {NUM_PAIRS{sout_ff[pft_pkg::DATA_W-1]}} & pair_ff;
  assign prog_serial_data_pin_oe_out = {NUM_PAIRS{scnt_ff != '0}} & pair_ff;
  assign serial_mode_out = ser_mode;

  // ----------------------------------------------------------------
  // Request selection.
  // ----------------------------------------------------------------
  assign f_cmd = frame_ff[pft_pkg::SER_FRAME_W-1 -: pft_pkg::SER_CMD_W];
  assign f_addr = frame_ff[pft_pkg::DATA_W +: pft_pkg::ADDR_W];
  assign f_data = frame_ff[pft_pkg::DATA_W-1:0];
  assign tbl_ready_out = !ser_mode && !nv.busy;

  always_comb begin
    op_go = 1'b0;
    op_ser = 1'b0;
    op_kind = pft_pkg::PFT_RD_LOW;
    op_byte = 1'b0;
    op_addr = '0;
    op_wdata = '0;
    nv_go = 1'b0;
    nv_kind = pft_pkg::PFT_NV_ROW;
    if (ser_mode) begin
      op_addr = f_addr;
      op_wdata = f_data;
      op_ser = 1'b1;
      if (frame_rdy_ff && !nv.busy) begin
        unique case (f_cmd)
          pft_pkg::SER_RD_LOW: op_go = 1'b1;
          pft_pkg::SER_RD_HIGH: begin
            op_go = 1'b1;
            op_kind = pft_pkg::PFT_RD_HIGH;
          end
          pft_pkg::SER_WR_LOW: begin
            op_go = 1'b1;
            op_kind = pft_pkg::PFT_WR_LOW;
          end
          pft_pkg::SER_WR_HIGH: begin
            op_go = 1'b1;
            op_kind = pft_pkg::PFT_WR_HIGH;
          end
          pft_pkg::SER_ROW: nv_go = 1'b1;
          pft_pkg::SER_WORD: begin
            nv_go = 1'b1;
            nv_kind = pft_pkg::PFT_NV_WORD;
          end
          pft_pkg::SER_ERASE: begin
            nv_go = 1'b1;
            nv_kind = pft_pkg::PFT_NV_ERASE;
          end
          default: op_go = 1'b0;
        endcase
      end
    end else begin
      op_addr = {page_ff, operand_pointer_address_in};
      op_wdata = tbl_wdata_in;
      op_kind = tbl_op_in;
      op_byte = tbl_byte_mode_in;
      op_go = tbl_valid_in && tbl_ready_out;
      nv_go = nv_valid_in && !nv.busy && !tbl_valid_in;
      nv_kind = nv_cmd_in;
    end
  end

  assign op_idx = op_addr[IDX_W:1];
  assign lat_idx = op_idx[pft_pkg::ROW_IDX_W-1:0];

  // ----------------------------------------------------------------
  // Page register and table reads.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      page_ff <= pft_pkg::PAGE_RESET;
    end else if (page_wr_in) begin
      page_ff <= page_data_in;
    end
  end

  assign table_page_select_out = page_ff;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ack_ff <= 1'b0;
      ack_ser_ff <= 1'b0;
      rdata_ff <= '0;
    end else begin
      ack_ff <= op_go;
      ack_ser_ff <= op_go && op_ser;
      if (op_go && (op_kind == pft_pkg::PFT_RD_LOW || op_kind == pft_pkg::PFT_RD_HIGH)) begin
        rdata_ff <= fmt_read(op_kind, op_byte, op_addr[0], mem_ff[op_idx]);
      end
    end
  end

  assign tbl_ack_out = ack_ff && !ack_ser_ff;
  assign tbl_rdata_out = rdata_ff;

  // ----------------------------------------------------------------
  // Table writes into the row latches.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < pft_pkg::ROW_INSTR; i++) begin
        latch_ff[i] <= pft_pkg::ERASED_WORD;
      end
    end else if (op_go && op_kind == pft_pkg::PFT_WR_LOW) begin
      if (!op_byte) begin
        latch_ff[lat_idx][pft_pkg::LOW_MSB:0] <= op_wdata;
      end else if (op_addr[0]) begin
        latch_ff[lat_idx][pft_pkg::LOW_MSB:pft_pkg::BYTE_W] <= op_wdata[pft_pkg::BYTE_W-1:0];
      end else begin
        latch_ff[lat_idx][pft_pkg::BYTE_W-1:0] <= op_wdata[pft_pkg::BYTE_W-1:0];
      end
    end else if (op_go && op_kind == pft_pkg::PFT_WR_HIGH && (!op_byte || !op_addr[0])) begin
      latch_ff[lat_idx][pft_pkg::HIGH_MSB:pft_pkg::HIGH_LSB] <= op_wdata[pft_pkg::BYTE_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Row program, word program and page erase.
  // ----------------------------------------------------------------
  assign nv.start = nv_go;
  assign nv.cmd = nv_kind;
  assign nv_busy_out = nv.busy;
  assign nv_done_out = nv.done;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      base_ff <= '0;
      nv_cmd_ff <= pft_pkg::PFT_NV_ROW;
    end else if (nv_go) begin
      nv_cmd_ff <= nv_kind;
      unique case (nv_kind)
        pft_pkg::PFT_NV_ROW: base_ff <= op_idx & ~IDX_W'(pft_pkg::ROW_INSTR - 1);
        pft_pkg::PFT_NV_WORD: base_ff <= op_idx;
        default: base_ff <= op_idx & ~IDX_W'(pft_pkg::PAGE_INSTR - 1);
      endcase
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (nv.step_valid) begin
      unique case (nv_cmd_ff)
        pft_pkg::PFT_NV_ROW:
          mem_ff[base_ff + IDX_W'(nv.step_idx)] <= latch_ff[nv.step_idx[pft_pkg::ROW_IDX_W-1:0]];
        pft_pkg::PFT_NV_WORD:
          mem_ff[base_ff] <= latch_ff[base_ff[pft_pkg::ROW_IDX_W-1:0]];
        default: mem_ff[base_ff + IDX_W'(nv.step_idx)] <= pft_pkg::ERASED_WORD;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  property p_ack;
    tbl_valid_in && tbl_ready_out |=> tbl_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("table request not answered");

  property p_busy_block;
    nv_busy_out |-> !tbl_ready_out ##1 !tbl_ack_out;
  endproperty
  a_busy_block: assert property (p_busy_block) else $error("ready while busy");

  property p_addr;
    (op_go && !ser_mode) |-> op_idx == IDX_W'({page_ff, operand_pointer_address_in} >> 1);
  endproperty
  a_addr: assert property (p_addr) else $error("address not page over pointer");

  property p_high_word;
    (tbl_valid_in && tbl_ready_out && tbl_op_in == pft_pkg::PFT_RD_HIGH && !tbl_byte_mode_in)
      |=> tbl_rdata_out[15:8] == 8'h00 && tbl_rdata_out[7:0] == $past(mem_ff[op_idx][23:16]);
  endproperty
  a_high_word: assert property (p_high_word) else $error("high word read wrong");

  property p_high_odd;
    (tbl_valid_in && tbl_ready_out && tbl_op_in == pft_pkg::PFT_RD_HIGH && tbl_byte_mode_in
      && operand_pointer_address_in[0]) |=> tbl_rdata_out == 16'h0000;
  endproperty
  a_high_odd: assert property (p_high_odd) else $error("phantom byte not zero");

  property p_wr_low;
    (op_go && op_kind == pft_pkg::PFT_WR_LOW && !op_byte)
      |=> latch_ff[$past(lat_idx)][15:0] == $past(op_wdata);
  endproperty
  a_wr_low: assert property (p_wr_low) else $error("low word not stored");

  property p_wr_byte;
    (op_go && op_kind == pft_pkg::PFT_WR_LOW && op_byte && !op_addr[0])
      |=> latch_ff[$past(lat_idx)][23:8] == $past(latch_ff[lat_idx][23:8]);
  endproperty
  a_wr_byte: assert property (p_wr_byte) else $error("byte write spilled");

  property p_wr_high;
    (op_go && op_kind == pft_pkg::PFT_WR_HIGH && !op_byte)
      |=> latch_ff[$past(lat_idx)][23:16] == $past(op_wdata[7:0]);
  endproperty
  a_wr_high: assert property (p_wr_high) else $error("high part not stored");

  property p_ser_frame;
    (serial_mode_out && frame_rdy_ff && !nv_busy_out && f_cmd <= pft_pkg::SER_WR_HIGH)
      |=> ack_ff && ack_ser_ff;
  endproperty
  a_ser_frame: assert property (p_ser_frame) else $error("serial frame not issued");
endmodule

// file: tb/pft_prog_model.sv
// Purpose: External serial programmer model driving one clock and data pair.
// Assumes: Each serial clock phase lasts 5 system clocks.
// Notes: The clock idles low between frames; the other pairs stay still.
`timescale 1ns/1ps
module pft_prog_model #(
  parameter int PAIR = 1
) (
  input wire logic clk_sys_in,
  input wire logic [2:0] sd_in,
  output logic [2:0] sck_out,
  output logic [2:0] sd_out,
  output logic master_clear_reset_n_out
);
  initial begin
    sck_out = 3'h0;
    sd_out = 3'h0;
    master_clear_reset_n_out = 1'b1;
  end

  task automatic ph();
    repeat (5) @(posedge clk_sys_in);
  endtask

  // Sends one frame MSB first, then clocks out 16 read-back bits if asked.
  task automatic frame(input logic [2:0] c, input logic [23:0] a, input logic [15:0] d,
                       input logic rd, output logic [15:0] q);
    logic [42:0] f;
    f = {c, a, d};
    q = 16'h0000;
    master_clear_reset_n_out <= 1'b0;
    ph();
    ph();
    for (int i = 42; i >= 0; i--) begin
      sd_out[PAIR] <= f[i];
      ph();
      sck_out[PAIR] <= 1'b1;
      ph();
      sck_out[PAIR] <= 1'b0;
    end
    sd_out[PAIR] <= ~f[0];
    ph();
    for (int i = 15; i >= 0 && rd; i--) begin
      q[i] = sd_in[PAIR];
      sck_out[PAIR] <= 1'b1;
      ph();
      sck_out[PAIR] <= 1'b0;
      ph();
    end
    master_clear_reset_n_out <= 1'b1;
  endtask
endmodule

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the program flash table access block.
// Assumes: Table reads are compared by a monitor against notes queued by the driver.
// Notes: A small flash size keeps the run short.
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, rst, pw, tv, bm, nvv, rdy, ack, busy, done, smode, master_clear_reset_n, rdy_smp;
  logic [7:0] pd, pg;
  logic [15:0] ea, wd, rdat, sq, a;
  logic [2:0] sck, msd, sdi, sdo, soe;
  logic [16:0] e;
  pft_pkg::pft_tbl_op_t top;
  pft_pkg::pft_nv_cmd_t nc;
  logic [16:0] q[$];
  logic [15:0] lo[64];
  logic [7:0] hi[64];
  logic [31:0] seed;
  int n_errors = 0;
  int checked = 0;

  assign sdi = (soe & sdo) | (~soe & msd);

  pft_top #(.FLASH_INSTR(2048), .NUM_PAIRS(3)) i_pft_top (
    .clk_sys_in(clk_sys), .rst_in(rst), .page_wr_in(pw), .page_data_in(pd),
    .table_page_select_out(pg), .tbl_valid_in(tv), .tbl_ready_out(rdy), .tbl_op_in(top),
    .tbl_byte_mode_in(bm), .operand_pointer_address_in(ea), .tbl_wdata_in(wd),
    .tbl_ack_out(ack), .tbl_rdata_out(rdat), .nv_valid_in(nvv), .nv_cmd_in(nc),
    .nv_busy_out(busy), .nv_done_out(done), .master_clear_reset_n_in(master_clear_reset_n),
    .prog_serial_clock_pin_in(sck), .prog_serial_data_pin_in(sdi),
    .prog_serial_data_pin_out(sdo), .prog_serial_data_pin_oe_out(soe), .serial_mode_out(smode));

  pft_prog_model #(.PAIR(1)) i_pft_prog_model (.clk_sys_in(clk_sys), .sd_in(sdi),
    .sck_out(sck), .sd_out(msd), .master_clear_reset_n_out(master_clear_reset_n));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    checked++;
    if (s !== x) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Raises a table request and holds it until the edge where ready is high.
  task automatic tbl(input pft_pkg::pft_tbl_op_t op, input logic b, input logic [15:0] ad,
                     input logic [15:0] d, input logic [15:0] x);
    tv <= 1'b1;
    top <= op;
    bm <= b;
    ea <= ad;
    wd <= d;
    q.push_back({(op == pft_pkg::PFT_RD_LOW || op == pft_pkg::PFT_RD_HIGH), x});
    do @(posedge clk_sys); while (rdy_smp !== 1'b1);
  endtask

  task automatic idle();
    tv <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic nv(input pft_pkg::pft_nv_cmd_t c, input logic [15:0] ad, input int n);
    int k;
    k = 0;
    nvv <= 1'b1;
    nc <= c;
    ea <= ad;
    @(posedge clk_sys);
    nvv <= 1'b0;
    @(negedge clk_sys);
    chk({15'h0000, rdy}, 16'h0000);
    while (busy === 1'b1 && k < 1000) begin
      k++;
      @(negedge clk_sys);
    end
    chk(16'(k), 16'(n));
    chk({15'h0000, done}, 16'h0001);
    @(posedge clk_sys);
  endtask

  always @(negedge clk_sys) rdy_smp <= rdy;

  // Takes the oldest note on every acknowledge and compares read data.
  always @(negedge clk_sys) begin
    if (ack === 1'b1) begin
      e = (q.size() > 0) ? q.pop_front() : 17'h1_dead;
      if (e[16])
        chk(rdat, e[15:0]);
    end
  end

  initial begin
    repeat (10000) @(posedge clk_sys);
    n_errors++;
    wrap_up();
  end

  initial begin
    {rst, pw, tv, bm, nvv} = 5'b1_0000;
    {pd, ea, wd} = 40'h00_0000_0000;
    top = pft_pkg::PFT_RD_LOW;
    nc = pft_pkg::PFT_NV_ROW;
    seed = 32'h4a7d_963b;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk({8'h00, pg}, 16'h0000);
    @(posedge clk_sys);
    pw <= 1'b1;
    pd <= 8'h5a;
    @(posedge clk_sys);
    pw <= 1'b0;
    pd <= 8'h00;
    @(negedge clk_sys);
    chk({8'h00, pg}, 16'h005a);
    @(posedge clk_sys);
    $display("test page done");
    nv(pft_pkg::PFT_NV_ERASE, 16'h05fe, 512);
    tbl(pft_pkg::PFT_RD_LOW, 1'b0, 16'h0578, 16'h0000, 16'hffff);
    tbl(pft_pkg::PFT_RD_HIGH, 1'b0, 16'h07fe, 16'h0000, 16'h00ff);
    $display("test erase done");
    for (int i = 0; i < 64; i++) begin
      seed = lfsr(seed);
      lo[i] = seed[15:0];
      hi[i] = seed[23:16];
      a = 16'h0400 + 16'(2 * i);
      tbl(pft_pkg::PFT_WR_LOW, 1'b0, a, lo[i], 16'h0000);
      tbl(pft_pkg::PFT_WR_HIGH, 1'b0, a, seed[31:16], 16'h0000);
    end
    idle();
    nv(pft_pkg::PFT_NV_ROW, 16'h0440, 64);
    for (int i = 0; i < 64; i++) begin
      a = 16'h0400 + 16'(2 * i);
      tbl(pft_pkg::PFT_RD_LOW, 1'b0, a, 16'h0000, lo[i]);
      tbl(pft_pkg::PFT_RD_HIGH, 1'b0, a, 16'h0000, {8'h00, hi[i]});
      tbl(pft_pkg::PFT_RD_LOW, 1'b1, a + 16'h0001, 16'h0000, {8'h00, lo[i][15:8]});
      tbl(pft_pkg::PFT_RD_HIGH, 1'b1, a, 16'h0000, {8'h00, hi[i]});
      tbl(pft_pkg::PFT_RD_HIGH, 1'b1, a + 16'h0001, 16'h0000, 16'h0000);
    end
    idle();
    $display("test row done");
    tbl(pft_pkg::PFT_WR_LOW, 1'b0, 16'h04b0, 16'h1234, 16'h0000);
    tbl(pft_pkg::PFT_WR_LOW, 1'b1, 16'h04b1, 16'hffab, 16'h0000);
    tbl(pft_pkg::PFT_WR_LOW, 1'b1, 16'h04b0, 16'h3356, 16'h0000);
    tbl(pft_pkg::PFT_WR_HIGH, 1'b1, 16'h04b0, 16'h995c, 16'h0000);
    tbl(pft_pkg::PFT_WR_HIGH, 1'b1, 16'h04b1, 16'h0011, 16'h0000);
    idle();
    nv(pft_pkg::PFT_NV_WORD, 16'h04b0, 1);
    tbl(pft_pkg::PFT_RD_LOW, 1'b0, 16'h04b0, 16'h0000, 16'hab56);
    tbl(pft_pkg::PFT_RD_HIGH, 1'b0, 16'h04b0, 16'h0000, 16'h005c);
    tbl(pft_pkg::PFT_RD_LOW, 1'b0, 16'h04b2, 16'h0000, 16'hffff);
    idle();
    $display("test word done");
    fork
      i_pft_prog_model.frame(pft_pkg::SER_RD_LOW, 24'h00_0402, 16'h0000, 1'b1, sq);
      begin
        repeat (20) @(negedge clk_sys);
        chk({15'h0000, smode}, 16'h0001);
        chk({15'h0000, rdy}, 16'h0000);
      end
    join
    chk(sq, lo[1]);
    repeat (10) @(posedge clk_sys);
    chk({15'h0000, rdy}, 16'h0001);
    i_pft_prog_model.frame(pft_pkg::SER_WR_LOW, 24'h00_0404, 16'hbeef, 1'b0, sq);
    repeat (10) @(posedge clk_sys);
    i_pft_prog_model.frame(pft_pkg::SER_WORD, 24'h00_0404, 16'h0000, 1'b0, sq);
    repeat (10) @(posedge clk_sys);
    tbl(pft_pkg::PFT_RD_LOW, 1'b0, 16'h0404, 16'h0000, 16'hbeef);
    idle();
    @(negedge clk_sys);
    chk(16'(q.size()), 16'h0000);
    $display("test serial done");
    wrap_up();
  end
endmodule
